/* hw/cil_pkg.sv */
// Shared constants of the core interrupt logic: register map, fields, resets.
// Assumes a 32-bit APB with byte addresses in the low eight bits.
package cil_pkg;
  localparam int CIL_AW = 8;
  localparam int CIL_NPEND = 8;
  localparam int CIL_NHW = 5;
  localparam int CIL_NSW = 2;
  localparam int CIL_NEVT = 2;
  // Register offsets
  localparam logic [7:0] CIL_OFS_STATUS = 8'h00;
  localparam logic [7:0] CIL_OFS_CAUSE = 8'h04;
  localparam logic [7:0] CIL_OFS_INTREG = 8'h08;
  localparam logic [7:0] CIL_OFS_COUNT = 8'h0C;
  localparam logic [7:0] CIL_OFS_COMPARE = 8'h10;
  localparam logic [7:0] CIL_OFS_EVT_STAT = 8'h14;
  localparam logic [7:0] CIL_OFS_EVT_CLR = 8'h18;
  localparam logic [7:0] CIL_OFS_EVT_EN = 8'h1C;
  // Field positions
  localparam int CIL_ST_GIE = 0;
  localparam int CIL_ST_XLVL = 1;
  localparam int CIL_ST_MASK_LO = 8;
  localparam int CIL_CA_SW_LO = 8;
  localparam int CIL_CA_HW_LO = 10;
  localparam int CIL_CA_TMR = 15;
  localparam int CIL_EV_NMI = 0;
  localparam int CIL_EV_TMR = 1;
  // Reset values
  localparam logic CIL_RST_GIE = 1'b0;
  localparam logic CIL_RST_XLVL = 1'b1;
  localparam logic [7:0] CIL_RST_MASK = 8'h00;
  localparam logic [1:0] CIL_RST_SW = 2'h0;
  localparam logic [4:0] CIL_RST_INTREG = 5'h00;
  localparam logic [31:0] CIL_RST_COUNT = 32'h0000_0000;
  localparam logic [31:0] CIL_RST_COMPARE = 32'hFFFF_FFFF;
  localparam logic [1:0] CIL_RST_EVT = 2'h0;
endpackage

/* hw/cil_mask.sv */
// Per-bit masking of the pending field and global gating.
// Assumes all inputs come from flops of the same clock.
`timescale 1ns/10ps
module cil_mask import cil_pkg::*; #(
  parameter int N = CIL_NPEND
) (
  // Sources
  input wire logic [N-1:0] pend,
  input wire logic [N-1:0] mask,
  // Gates
  input wire logic gate_en,
  input wire logic gate_lvl,
  // Result
  output logic req
);
  logic [N-1:0] prod;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      assign prod[i] = pend[i] & mask[i];
    end
  endgenerate

  // Enabled only with global enable set and exception level clear
  assign req = (|prod) & gate_en & ~gate_lvl;
endmodule

/* hw/cil_timer.sv */
// Count/compare timer with sticky match pending bit.
// Assumes one write strobe per register, taken on the same clock.
`timescale 1ns/10ps
module cil_timer import cil_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register writes
  input wire logic wr_count,
  input wire logic wr_cmp,
  input wire logic [31:0] wdata,
  // State
  output logic [31:0] count,
  output logic [31:0] compare,
  output logic match,
  output logic pend
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= CIL_RST_COUNT;
    end else if (wr_count) begin
      count <= wdata;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare <= CIL_RST_COMPARE;
    end else if (wr_cmp) begin
      compare <= wdata;
    end
  end

  assign match = (count == compare);

  // Set wins over the clear done by a compare write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (match) begin
      pend <= 1'b1;
    end else if (wr_cmp) begin
      pend <= 1'b0;
    end
  end
endmodule

/* hw/cil_top.sv */
// Core interrupt logic: NMI capture and redirect, pending/mask/enable gating,
// count/compare timer, APB register file and a summary event interrupt.
// Assumes all inputs synchronous to clk, which is the core master clock.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module cil_top import cil_pkg::*; #(
  parameter logic [31:0] RESET_VECTOR = 32'h0000_1000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CIL_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources and pipeline
  input wire logic nmi_line_n,
  input wire logic [CIL_NHW-1:0] int_lines,
  input wire logic pipe_run,
  // Pipeline requests
  output logic core_int,
  output logic nmi_redirect,
  output logic [31:0] redirect_pc,
  // Event interrupt
  output logic irq
);
  logic setup;
  logic wr;
  logic global_int_enable;
  logic exception_level_bit;
  logic [CIL_NPEND-1:0] int_mask_field;
  logic [CIL_NSW-1:0] sw_pend;
  logic [CIL_NHW-1:0] intreg;
  logic [CIL_NPEND-1:0] int_pending_field;
  logic [CIL_NEVT-1:0] evt_stat;
  logic [CIL_NEVT-1:0] evt_en;
  logic [CIL_NEVT-1:0] evt_set;
  logic [31:0] count;
  logic [31:0] compare;
  logic tmr_match;
  logic tmr_pend;
  logic next_core_int;
  logic nmi_req;
  logic nmi_req_d;
  logic nmi_pend;
  logic nmi_take;
  logic [31:0] rd_data;
  logic rd_err;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;

  // Pending field: timer, hardware lines ORed with internal bits, software
  assign int_pending_field = {tmr_pend, intreg | int_lines, sw_pend};

  // Count and compare timer
  cil_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .wr_count(wr && paddr == CIL_OFS_COUNT),
    .wr_cmp(wr && paddr == CIL_OFS_COMPARE),
    .wdata(pwdata),
    .count(count),
    .compare(compare),
    .match(tmr_match),
    .pend(tmr_pend)
  );

  // Pending mask and global gates
  cil_mask #(.N(CIL_NPEND)) u_mask (
    .pend(int_pending_field),
    .mask(int_mask_field),
    .gate_en(global_int_enable),
    .gate_lvl(exception_level_bit),
    .req(next_core_int)
  );

  // Status register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_int_enable <= CIL_RST_GIE;
      exception_level_bit <= CIL_RST_XLVL;
      int_mask_field <= CIL_RST_MASK;
    end else if (wr && paddr == CIL_OFS_STATUS) begin
      global_int_enable <= pwdata[CIL_ST_GIE];
      exception_level_bit <= pwdata[CIL_ST_XLVL];
      int_mask_field <= pwdata[CIL_ST_MASK_LO +: CIL_NPEND];
    end
  end

  // Software pending bits: no hardware path sets or clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_pend <= CIL_RST_SW;
    end else if (wr && paddr == CIL_OFS_CAUSE) begin
      sw_pend <= pwdata[CIL_CA_SW_LO +: CIL_NSW];
    end
  end

  // Internal interrupt register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intreg <= CIL_RST_INTREG;
    end else if (wr && paddr == CIL_OFS_INTREG) begin
      intreg <= pwdata[CIL_NHW-1:0];
    end
  end

  // Level request, re-evaluated every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_int <= 1'b0;
    end else begin
      core_int <= next_core_int;
    end
  end

  // NMI line captured on the master clock rise and inverted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_req <= 1'b0;
      nmi_req_d <= 1'b0;
    end else begin
      nmi_req <= ~nmi_line_n;
      nmi_req_d <= nmi_req;
    end
  end

  // Held until the pipeline runs; new edge wins over the take
  assign nmi_take = nmi_pend & pipe_run;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pend <= 1'b0;
    end else if (nmi_req & ~nmi_req_d) begin
      nmi_pend <= 1'b1;
    end else if (nmi_take) begin
      nmi_pend <= 1'b0;
    end
  end

  // Redirect pulse and held vector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_redirect <= 1'b0;
      redirect_pc <= 32'h0000_0000;
    end else begin
      nmi_redirect <= nmi_take;
      if (nmi_take) begin
        redirect_pc <= RESET_VECTOR;
      end
    end
  end

  // Sticky events; set wins over the clear
  assign evt_set[CIL_EV_NMI] = nmi_take;
  assign evt_set[CIL_EV_TMR] = tmr_match;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_stat <= CIL_RST_EVT;
    end else if (wr && paddr == CIL_OFS_EVT_CLR) begin
      evt_stat <= (evt_stat & ~pwdata[CIL_NEVT-1:0]) | evt_set;
    end else begin
      evt_stat <= evt_stat | evt_set;
    end
  end

  // Event enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_en <= CIL_RST_EVT;
    end else if (wr && paddr == CIL_OFS_EVT_EN) begin
      evt_en <= pwdata[CIL_NEVT-1:0];
    end
  end

  // Summary event interrupt, one cycle behind the status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_stat & evt_en);
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      CIL_OFS_STATUS: begin
        rd_data[CIL_ST_GIE] = global_int_enable;
        rd_data[CIL_ST_XLVL] = exception_level_bit;
        rd_data[CIL_ST_MASK_LO +: CIL_NPEND] = int_mask_field;
      end
      CIL_OFS_CAUSE: begin
        rd_data[CIL_CA_SW_LO +: CIL_NSW] = sw_pend;
        rd_data[CIL_CA_HW_LO +: CIL_NHW] = intreg | int_lines;
        rd_data[CIL_CA_TMR] = tmr_pend;
      end
      CIL_OFS_INTREG: rd_data[CIL_NHW-1:0] = intreg;
      CIL_OFS_COUNT: rd_data = count;
      CIL_OFS_COMPARE: rd_data = compare;
      CIL_OFS_EVT_STAT: rd_data[CIL_NEVT-1:0] = evt_stat;
      CIL_OFS_EVT_CLR: rd_data = 32'h0000_0000;
      CIL_OFS_EVT_EN: rd_data[CIL_NEVT-1:0] = evt_en;
      default: rd_err = 1'b1;
    endcase
  end

  // No wait state: answer prepared in the setup cycle, pready high in the first access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & rd_err;
      if (setup && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  // Rule checks
  AST_NMI_VECTOR: assert property (@(posedge clk) disable iff (!rst_n)
    nmi_redirect |-> redirect_pc == RESET_VECTOR) else $error("NMI redirect without reset vector");
  AST_NMI_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 nmi_req == !$past(nmi_line_n)) else $error("NMI request not inverted capture");
  AST_NMI_RUN_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    nmi_redirect |-> $past(pipe_run) && $past(nmi_pend)) else $error("NMI taken while stalled");
  AST_NMI_UNMASKED: assert property (@(posedge clk) disable iff (!rst_n)
    (nmi_pend && pipe_run && !global_int_enable) |=> nmi_redirect) else $error("NMI blocked");
  AST_SW_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && paddr == CIL_OFS_CAUSE) |=> $stable(sw_pend)) else $error("Software pending changed");
  AST_TIMER_SET: assert property (@(posedge clk) disable iff (!rst_n)
    count == compare |=> tmr_pend) else $error("Timer match not pending");
  AST_CAUSE_TMR: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && paddr == CIL_OFS_CAUSE) |=> prdata[CIL_CA_TMR] == $past(tmr_pend))
    else $error("Cause bit 15 wrong");
  AST_CAUSE_HW: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && paddr == CIL_OFS_CAUSE)
    |=> prdata[14:10] == ($past(intreg) | $past(int_lines))) else $error("Cause hardware bits wrong");
  AST_INT_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 core_int == (|($past(int_pending_field) & $past(int_mask_field)) & $past(global_int_enable)
    & !$past(exception_level_bit)))
    else $error("Core interrupt level wrong");
  AST_IE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    (!global_int_enable || exception_level_bit) |=> !core_int) else $error("Gated interrupt raised");

  // Pending, mask and gate path
  AST_SW_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && paddr == CIL_OFS_CAUSE) |=> sw_pend == $past(pwdata[9:8]))
    else $error("Software pending write lost");
  AST_CAUSE_SW: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && paddr == CIL_OFS_CAUSE) |=> prdata[9:8] == $past(sw_pend))
    else $error("Cause software bits wrong");
  AST_TIMER_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (tmr_pend && !(wr && paddr == CIL_OFS_COMPARE)) |=> tmr_pend) else $error("Timer pending lost");
  AST_CORE_INT_TIMER: assert property (@(posedge clk) disable iff (!rst_n)
    (tmr_pend && int_mask_field[7] && global_int_enable && !exception_level_bit) |=> core_int)
    else $error("Timer request not forwarded");
  AST_HW_TO_INT: assert property (@(posedge clk) disable iff (!rst_n)
    (((intreg | int_lines) & int_mask_field[6:2]) != 5'h00 && global_int_enable && !exception_level_bit)
    |=> core_int) else $error("Hardware request not forwarded");
  AST_SW_TO_INT: assert property (@(posedge clk) disable iff (!rst_n)
    ((sw_pend & int_mask_field[1:0]) != 2'h0 && global_int_enable && !exception_level_bit)
    |=> core_int) else $error("Software request not forwarded");
  AST_NO_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    (int_mask_field == 8'h00) |=> !core_int) else $error("Interrupt with all sources masked");

  // Non-maskable path
  AST_NMI_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (nmi_pend && !pipe_run) |=> nmi_pend) else $error("NMI dropped while stalled");
  AST_NMI_TAKE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    (nmi_take && !(nmi_req && !nmi_req_d)) |=> !nmi_pend) else $error("NMI pending after take");
  AST_REDIRECT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !nmi_take |=> $stable(redirect_pc)) else $error("Redirect target moved");

  // Main scenarios
  CV_CORE_INT: cover property (@(posedge clk) disable iff (!rst_n) $rose(core_int));
  CV_NMI: cover property (@(posedge clk) disable iff (!rst_n) nmi_redirect);
  CV_TIMER: cover property (@(posedge clk) disable iff (!rst_n) tmr_match ##1 irq);
  CV_NMI_HELD: cover property (@(posedge clk) disable iff (!rst_n) (nmi_pend && !pipe_run) ##1 nmi_pend);
  CV_SW_INT: cover property (@(posedge clk) disable iff (!rst_n) (|sw_pend) && core_int);
endmodule

/* test/cil_src_model.sv */
// Model of the system side: NMI line, hardware lines, pipeline run.
// Assumes its tasks are called just after a rising edge of clk.
`timescale 1ns/10ps
module cil_src_model (
  // Clock
  input wire logic clk,
  // Sources to the core
  output logic nmi_line_n,
  output logic [4:0] int_lines,
  output logic pipe_run
);
  initial begin
    nmi_line_n = 1'h1;
    int_lines = 5'h00;
    pipe_run = 1'h0;
  end
  task automatic nmi_pulse();
    @(posedge clk);
    nmi_line_n <= 1'h0;
    repeat (2) @(posedge clk);
    nmi_line_n <= 1'h1;
  endtask
  task automatic set_lines(input logic [3:0] v);
    int_lines <= {1'h0, v};
  endtask
  task automatic set_run(input logic r);
    pipe_run <= r;
  endtask
endmodule

/* test/cil_tb_top.sv */
// Self-checking bench of the core interrupt logic over APB.
// Assumes the source model drives the NMI, hardware lines and pipeline run.
`timescale 1ns/10ps
module cil_tb_top;
  import cil_pkg::*;
  localparam logic [31:0] VEC = 32'h0000_2A40;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic nmi_line_n, pipe_run, core_int, nmi_redirect, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, redirect_pc, rdat;
  logic [4:0] int_lines;
  int fail_count, tests_run, cyc;

  cil_top #(.RESET_VECTOR(VEC)) u_cil_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_line_n(nmi_line_n), .int_lines(int_lines), .pipe_run(pipe_run), .core_int(core_int),
    .nmi_redirect(nmi_redirect), .redirect_pc(redirect_pc), .irq(irq));
  cil_src_model u_cil_src_model (.clk(clk), .nmi_line_n(nmi_line_n), .int_lines(int_lines),
    .pipe_run(pipe_run));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask
  // One APB transfer; waits for pready, the hang guard ends a stuck wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1);
    chk("access cycles", 32'h1, 32'(n));
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(nm, exp, rdat);
    chk({nm, " err"}, 32'h0, 32'(err));
  endtask
  task automatic ci(input string nm, input logic e);
    repeat (2) @(posedge clk);
    chk(nm, 32'(e), 32'(core_int));
  endtask

  task automatic t_reset();
    chk("redirect pc reset", 32'h0, redirect_pc);
    chk("irq reset", 32'h0, 32'(irq));
    rd("status", CIL_OFS_STATUS, 32'h2);
    rd("cause", CIL_OFS_CAUSE, 32'h0);
    rd("compare", CIL_OFS_COMPARE, 32'hFFFF_FFFF);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped rd err", 32'h1, 32'(err));
    chk("unmapped rd data", 32'h0, rdat);
    apb(1'h1, 8'h24, 32'hFFFF_FFFF);
    chk("unmapped wr err", 32'h1, 32'(err));
    ci("core_int idle", 1'h0);
  endtask

  task automatic t_sw();
    apb(1'h1, CIL_OFS_STATUS, 32'h101);
    apb(1'h1, CIL_OFS_CAUSE, 32'h100);
    ci("core_int sw0", 1'h1);
    u_cil_src_model.set_lines(4'hF);
    repeat (3) @(posedge clk);
    rd("cause sw kept", CIL_OFS_CAUSE, 32'h3D00);
    u_cil_src_model.set_lines(4'h0);
    apb(1'h1, CIL_OFS_STATUS, 32'h103);
    ci("core_int exl", 1'h0);
    apb(1'h1, CIL_OFS_STATUS, 32'h100);
    ci("core_int ie off", 1'h0);
    apb(1'h1, CIL_OFS_STATUS, 32'h201);
    ci("core_int mask1", 1'h0);
    apb(1'h1, CIL_OFS_CAUSE, 32'h200);
    ci("core_int sw1", 1'h1);
    apb(1'h1, CIL_OFS_CAUSE, 32'h0);
    ci("core_int sw clr", 1'h0);
  endtask

  task automatic t_hw();
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, CIL_OFS_STATUS, 32'h1 | (32'h400 << i));
      u_cil_src_model.set_lines(4'(1 << i));
      ci("core_int hw", 1'h1);
      rd("cause hw", CIL_OFS_CAUSE, 32'h400 << i);
      apb(1'h1, CIL_OFS_STATUS, 32'h1 | (32'h800 << i));
      ci("core_int hw masked", 1'h0);
      u_cil_src_model.set_lines(4'h0);
    end
    apb(1'h1, CIL_OFS_STATUS, 32'h4001);
    apb(1'h1, CIL_OFS_INTREG, 32'h10);
    ci("core_int intreg", 1'h1);
    rd("cause intreg", CIL_OFS_CAUSE, 32'h4000);
    apb(1'h1, CIL_OFS_INTREG, 32'h0);
    ci("core_int level", 1'h0);
  endtask

  task automatic t_timer();
    apb(1'h1, CIL_OFS_STATUS, 32'h8001);
    apb(1'h1, CIL_OFS_COMPARE, 32'h40);
    apb(1'h1, CIL_OFS_COUNT, 32'h0);
    ci("core_int early", 1'h0);
    repeat (80) @(posedge clk);
    rd("cause tmr", CIL_OFS_CAUSE, 32'h8000);
    ci("core_int tmr", 1'h1);
    rd("evt stat", CIL_OFS_EVT_STAT, 32'h2);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'h1, CIL_OFS_EVT_EN, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq on", 32'h1, 32'(irq));
    apb(1'h1, CIL_OFS_EVT_CLR, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    apb(1'h1, CIL_OFS_COMPARE, 32'hFFFF_FFFF);
    ci("core_int tmr clr", 1'h0);
  endtask

  task automatic t_nmi();
    int n;
    n = 0;
    apb(1'h1, CIL_OFS_STATUS, 32'h2);
    u_cil_src_model.nmi_pulse();
    repeat (10) begin
      @(posedge clk);
      if (nmi_redirect === 1'h1) n++;
    end
    chk("nmi halted", 32'h0, 32'(n));
    u_cil_src_model.set_run(1'h1);
    repeat (6) begin
      @(posedge clk);
      if (nmi_redirect === 1'h1) n++;
    end
    chk("nmi pulses", 32'h1, 32'(n));
    chk("redirect pc", VEC, redirect_pc);
    u_cil_src_model.nmi_pulse();
    repeat (6) begin
      @(posedge clk);
      if (nmi_redirect === 1'h1) n++;
    end
    chk("nmi second", 32'h2, 32'(n));
    rd("evt nmi", CIL_OFS_EVT_STAT, 32'h1);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_reset();
    t_sw();
    t_hw();
    t_timer();
    t_nmi();
    finish_test();
  end
endmodule
